/* File: sirq_pkg.sv */
`default_nettype none
package sirq_pkg;
  // byte addresses of the registers (word aligned)
  localparam logic [7:0] ADDR_ENABLE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_SELECT  = 8'h04;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_EVT_CLEAR   = 8'h0C;
  localparam logic [7:0] ADDR_EVT_ENABLE  = 8'h10;
  localparam logic [7:0] ADDR_LINK_STATUS = 8'h14;
  // enable control field positions
  localparam int BIT_DIRECT = 6;
  localparam int BIT_IRQ9   = 3;
  localparam int BIT_IRQ6   = 2;
  localparam int BIT_SMI    = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // serial frame slot numbers (slot 0 is smi, slot n is irq n)
  localparam int SLOT_SMI = 0;
  localparam int NUM_SLOTS = 16;
  // event status bits
  localparam int EVT_OBF_SET   = 0;
  localparam int EVT_OBF_CLEAR = 1;
  localparam int EVT_AUTO_OFF  = 2;
  localparam int NUM_EVT       = 3;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // request vector travelling to the serial frame side
  typedef struct packed {
    logic [15:0] slot_req;
  } sirq_req_t;
endpackage : sirq_pkg
`default_nettype wire

/* File: sirq_sync.sv */
`default_nettype none
// two flop synchroniser
module sirq_sync
(
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta;
  // first stage read only by second stage
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // sirq_sync
`default_nettype wire

/* File: sirq_frame.sv */
`default_nettype none
// serial irq slot driver: one frame per start low, slot data phase low when requested
module sirq_frame
(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             link_clk_rise,
  input  wire logic             sirq_line,
  input  wire sirq_pkg::sirq_req_t req,
  output var  logic             drive_low,
  output var  logic             in_frame
);
  typedef enum {SIRQ_IDLE, SIRQ_START, SIRQ_SLOTS} sirq_state_t;
  sirq_state_t state;
  logic [5:0]  phase;
  logic [3:0]  slot;
  // frame tracker: start pulse low, then three link clocks per slot
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= SIRQ_IDLE;
      phase <= 6'h0;
      slot  <= 4'h0;
    end
    else if (link_clk_rise)
    begin
      case (state)
        SIRQ_IDLE:
        begin
          if (!sirq_line)
            state <= SIRQ_START;
        end
        SIRQ_START:
        begin
          if (sirq_line)
          begin
            state <= SIRQ_SLOTS;
            phase <= 6'h0;
            slot  <= 4'h0;
          end
        end
        SIRQ_SLOTS:
        begin
          if (phase == 6'd2)
          begin
            phase <= 6'h0;
            if (slot == 4'(sirq_pkg::NUM_SLOTS - 1))
              state <= SIRQ_IDLE;
            else
              slot <= slot + 4'h1;
          end
          else
            phase <= phase + 6'h1;
        end
        default: state <= SIRQ_IDLE;
      endcase
    end
  end
  // low only during the sample phase of a requested slot, else released
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      drive_low <= 1'b0;
    else
      drive_low <= (state == SIRQ_SLOTS) && (phase == 6'h0) && req.slot_req[slot];
  end
  assign in_frame = (state != SIRQ_IDLE);
endmodule // sirq_frame
`default_nettype wire

/* File: sirq_ctrl.sv */
`default_nettype none
module sirq_ctrl
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // channel 4 data path and lpc resets
  input  wire logic        ch4_output_data_write_in,
  input  wire logic        ch4_obf_clear_in,
  input  wire logic        lpc_hw_reset_in,
  input  wire logic        lpc_sw_reset_in,
  // serirq link
  input  wire logic        link_clk_in,
  input  wire logic        serirq_in,
  output var  logic        serirq_out,
  output var  logic        serirq_oe_out,
  output var  logic        irq_out
);
  logic       link_clk_s;
  logic       link_clk_d;
  logic       serirq_s;
  logic       lpc_hw_s;
  logic       lpc_sw_s;
  logic       link_rise;
  logic       drive_low;
  logic       in_frame;
  logic       ch4_output_buffer_full;
  logic       ch4_direct_request_mode;
  logic       ch4_host_irq9_enable;
  logic       ch4_host_irq6_enable;
  logic       ch4_host_smi_enable;
  logic [2:0] read_zero;
  logic [7:0] serirq_host_irq_select;
  logic [2:0] evt_status;
  logic [2:0] evt_enable;
  logic [2:0] evt_set;
  logic       lpc_reset;
  logic       auto_off;
  sirq_pkg::sirq_req_t req;
  // captured address phase
  logic       dp_valid;
  logic       dp_write;
  logic [7:0] dp_addr;
  logic       wr_ctrl;
  logic       rd_ctrl_now;

  // link and lpc reset inputs cross into the clock domain
  sirq_sync u_sync_clk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(link_clk_in), .sync_out(link_clk_s));
  sirq_sync u_sync_dat (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(serirq_in), .sync_out(serirq_s));
  sirq_sync u_sync_hw  (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(lpc_hw_reset_in),
                        .sync_out(lpc_hw_s));
  sirq_sync u_sync_sw  (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(lpc_sw_reset_in),
                        .sync_out(lpc_sw_s));

  // link clock edge finder on the synchronised copy
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      link_clk_d <= 1'b0;
    else
      link_clk_d <= link_clk_s;
  end
  assign link_rise = link_clk_s && !link_clk_d;
  assign lpc_reset = lpc_hw_s || lpc_sw_s;

  // ahb address phase capture, zero wait states
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else if (hready)
    begin
      dp_valid <= hsel && (htrans == sirq_pkg::HTRANS_NONSEQ);
      dp_write <= hwrite;
      dp_addr  <= haddr;
    end
  end
  assign wr_ctrl     = dp_valid && dp_write && (dp_addr == sirq_pkg::ADDR_ENABLE_CTRL);
  assign rd_ctrl_now = hready && hsel && (htrans == sirq_pkg::HTRANS_NONSEQ) && !hwrite
                       && (haddr == sirq_pkg::ADDR_ENABLE_CTRL);

  // response is always okay and never stalls
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data registered during address phase
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && (htrans == sirq_pkg::HTRANS_NONSEQ) && !hwrite)
    begin
      case (haddr)
        sirq_pkg::ADDR_ENABLE_CTRL:
          hrdata <= {24'h00_0000, 1'b0, ch4_direct_request_mode, 2'b00, ch4_host_irq9_enable,
                     ch4_host_irq6_enable, ch4_host_smi_enable, 1'b0};
        sirq_pkg::ADDR_IRQ_SELECT:  hrdata <= {24'h00_0000, serirq_host_irq_select};
        sirq_pkg::ADDR_EVT_STATUS:  hrdata <= {29'h0000_0000, evt_status};
        sirq_pkg::ADDR_EVT_ENABLE:  hrdata <= {29'h0000_0000, evt_enable};
        sirq_pkg::ADDR_LINK_STATUS: hrdata <= {29'h0000_0000, in_frame, drive_low, ch4_output_buffer_full};
        default:                    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // output buffer full flag, set by output-data write, cleared by host read
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      ch4_output_buffer_full <= 1'b0;
    else if (ch4_output_data_write_in)
      ch4_output_buffer_full <= 1'b1;
    else if (ch4_obf_clear_in || lpc_reset)
      ch4_output_buffer_full <= 1'b0;
  end
  assign auto_off = !ch4_direct_request_mode && ch4_output_buffer_full && ch4_obf_clear_in
                    && !ch4_output_data_write_in;

  // direct mode bit
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      ch4_direct_request_mode <= 1'b0;
    else if (wr_ctrl)
      ch4_direct_request_mode <= hwdata[sirq_pkg::BIT_DIRECT];
  end

  // remembers which enables were last read as zero
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      read_zero <= 3'b000;
    else if (rd_ctrl_now)
      read_zero <= ~{ch4_host_irq9_enable, ch4_host_irq6_enable, ch4_host_smi_enable};
    // a write uses up the record, so a later write of 1 needs a fresh read
    else if (wr_ctrl)
      read_zero <= 3'b000;
  end

  // enable bits: set needs prior read of 0; write 0, lpc reset, flag clear outside direct mode all clear
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || lpc_reset)
    begin
      ch4_host_irq9_enable <= 1'b0;
      ch4_host_irq6_enable <= 1'b0;
      ch4_host_smi_enable  <= 1'b0;
    end
    else if (auto_off)
    begin
      ch4_host_irq9_enable <= 1'b0;
      ch4_host_irq6_enable <= 1'b0;
      ch4_host_smi_enable  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // reserved bit 0 ignored so a careless write cannot matter
      ch4_host_irq9_enable <= hwdata[sirq_pkg::BIT_IRQ9] && (ch4_host_irq9_enable || read_zero[2]);
      ch4_host_irq6_enable <= hwdata[sirq_pkg::BIT_IRQ6] && (ch4_host_irq6_enable || read_zero[1]);
      ch4_host_smi_enable  <= hwdata[sirq_pkg::BIT_SMI] && (ch4_host_smi_enable || read_zero[0]);
    end
  end

  // host irq select bits
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      serirq_host_irq_select <= sirq_pkg::RESET_BYTE;
    else if (dp_valid && dp_write && (dp_addr == sirq_pkg::ADDR_IRQ_SELECT))
      serirq_host_irq_select <= hwdata[7:0];
  end

  // merge qualified requests and select bits into slot vector
  always_comb
  begin
    logic qual;
    qual = ch4_direct_request_mode || ch4_output_buffer_full;
    req.slot_req      = 16'h0000;
    req.slot_req[9]   = ch4_host_irq9_enable && qual;
    req.slot_req[6]   = ch4_host_irq6_enable && qual;
    req.slot_req[sirq_pkg::SLOT_SMI] = ch4_host_smi_enable && qual;
    req.slot_req[15]  = serirq_host_irq_select[7];
    req.slot_req[14]  = serirq_host_irq_select[6];
    req.slot_req[13]  = serirq_host_irq_select[5];
    req.slot_req[8]   = serirq_host_irq_select[4];
    req.slot_req[7]   = serirq_host_irq_select[3];
    req.slot_req[5]   = serirq_host_irq_select[2];
    req.slot_req[4]   = serirq_host_irq_select[1];
    req.slot_req[3]   = serirq_host_irq_select[0];
  end

  sirq_frame u_frame
  (
    .ref_clk_in   (ref_clk_in),
    .rst_n_in     (rst_n_in),
    .link_clk_rise(link_rise),
    .sirq_line    (serirq_s),
    .req          (req),
    .drive_low    (drive_low),
    .in_frame     (in_frame)
  );

  // pin: drive low only in requested slots, otherwise released
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      serirq_out    <= 1'b0;
      serirq_oe_out <= 1'b0;
    end
    else
    begin
      serirq_out    <= 1'b0;
      serirq_oe_out <= drive_low;
    end
  end

  // event capture: set wins over clear
  assign evt_set = {auto_off, ch4_obf_clear_in && ch4_output_buffer_full, ch4_output_data_write_in};
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      evt_status <= 3'b000;
      evt_enable <= 3'b000;
    end
    else
    begin
      if (dp_valid && dp_write && (dp_addr == sirq_pkg::ADDR_EVT_ENABLE))
        evt_enable <= hwdata[2:0];
      if (dp_valid && dp_write && (dp_addr == sirq_pkg::ADDR_EVT_CLEAR))
        evt_status <= (evt_status & ~hwdata[2:0]) | evt_set;
      else
        evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(evt_status & evt_enable);
  end
endmodule // sirq_ctrl
`default_nettype wire

/* File: sirq_ctrl_checker.sv */
`default_nettype none
module sirq_ctrl_checker
(
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        link_clk_in,
  input wire logic        serirq_out,
  input wire logic        serirq_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic       rd;
  logic       lk;
  logic [4:0] still;
  // read address phase taken
  assign rd = hsel && hready && !hwrite && htrans == sirq_pkg::HTRANS_NONSEQ;
  // cycles since the link clock last moved
  always_ff @(posedge ref_clk_in)
  begin
    lk <= link_clk_in;
    if (!rst_n_in || lk != link_clk_in)
      still <= 5'h00;
    else if (still != 5'h1f)
      still <= still + 5'h01;
  end
  ready_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  drive_low_a: assert property (serirq_oe_out |-> !serirq_out) else $error("line driven high");
  drive_min_a: assert property ($rose(serirq_oe_out) |=> serirq_oe_out[*6]) else $error("slot drive short");
  drive_max_a: assert property ($rose(serirq_oe_out) |-> ##[1:12] !serirq_oe_out) else $error("slot drive long");
  drive_idle_a: assert property (serirq_oe_out |-> still < 5'h0c) else $error("drive outside frame");
  read_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
  unmapped_zero_a: assert property (rd && haddr > sirq_pkg::ADDR_LINK_STATUS |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ctrl_reserved_a: assert property (rd && haddr == sirq_pkg::ADDR_ENABLE_CTRL |=> (hrdata & 32'hffff_ffb1) == 0)
    else $error("reserved control bits set");
  select_width_a: assert property (rd && haddr == sirq_pkg::ADDR_IRQ_SELECT |=> hrdata[31:8] == 24'h00_0000)
    else $error("select upper bits set");
  cover property ($rose(serirq_oe_out));
  cover property (rd && haddr > sirq_pkg::ADDR_LINK_STATUS);
  cover property (rd && haddr == sirq_pkg::ADDR_IRQ_SELECT);
endmodule // sirq_ctrl_checker
bind sirq_ctrl sirq_ctrl_checker chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .link_clk_in(link_clk_in), .serirq_out(serirq_out), .serirq_oe_out(serirq_oe_out));
`default_nettype wire

/* File: sirq_host_model.sv */
`default_nettype none
module sirq_host_model
(
  input  wire logic        frame_go_in,
  input  wire logic        line_in,
  output var  logic        link_clk_out,
  output var  logic        start_low_out,
  output var  logic [15:0] slots_out,
  output var  int          frames_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock stands low and line is released between frames
  initial
  begin
    link_clk_out = 1'b0;
    start_low_out = 1'b0;
    slots_out = 16'h0000;
    frames_out = 0;
  end
  // start low across one rising edge, then 16 slots of 3 clocks
  always @(posedge frame_go_in)
  begin
    slots_out = 16'h0000;
    start_low_out = 1'b1;
    #200 link_clk_out = 1'b1;
    #200 link_clk_out = 1'b0;
    start_low_out = 1'b0;
    for (int i = 0; i < 51; i++)
    begin
      #199 if (i > 0 && i < 49 && line_in === 1'b0) slots_out[(i - 1) / 3] = 1'b1;
      #1 link_clk_out = 1'b1;
      #200 link_clk_out = 1'b0;
    end
    frames_out++;
  end
endmodule // sirq_host_model
`default_nettype wire

/* File: serirq_host_irq_ch4_select_bench.sv */
`default_nettype none
module serirq_host_irq_ch4_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEL_IRQ [8] = '{3, 4, 5, 7, 8, 13, 14, 15};
  localparam logic [7:0] EN [3] = '{8'h08, 8'h04, 8'h02};
  localparam logic [15:0] EXP [3] = '{16'h0200, 16'h0040, 16'h0001};
  logic        clk;
  logic        rst_n  = 1'b0;
  logic        hsel   = 1'b0;
  logic [7:0]  haddr  = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0]  ev     = 4'h0;
  logic        go     = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        lclk;
  logic        start_low;
  logic        sq_out;
  logic        sq_oe;
  logic        irq;
  logic        line;
  logic [15:0] slots;
  int          frames;
  int          num_errors  = 0;
  int          check_count = 0;
  // pulled-up line
  assign line = start_low ? 1'b0 : (sq_oe ? sq_out : 1'b1);
  sirq_ctrl DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch4_output_data_write_in(ev[0]), .ch4_obf_clear_in(ev[1]),
    .lpc_hw_reset_in(ev[2]), .lpc_sw_reset_in(ev[3]), .link_clk_in(lclk), .serirq_in(line),
    .serirq_out(sq_out), .serirq_oe_out(sq_oe), .irq_out(irq));
  sirq_host_model host (.frame_go_in(go), .line_in(line), .link_clk_out(lclk), .start_low_out(start_low),
    .slots_out(slots), .frames_out(frames));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // one single transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= sirq_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0000_0000, q);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask
  // irq output after the registered update
  task automatic ci(input logic e);
    repeat (3) @(posedge clk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask
  task automatic pulse(input int b, input int n);
    ev[b] <= 1'b1;
    repeat (n) @(posedge clk);
    ev[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // run one frame on the link and compare requested slots
  task automatic frame(input logic [15:0] e);
    int f;
    f = frames;
    go <= 1'b1;
    repeat (2) @(posedge clk);
    go <= 1'b0;
    repeat (600) if (frames == f) @(posedge clk);
    chk(frames - f, 32'h0000_0001);
    chk({16'h0000, slots}, {16'h0000, e});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #2000000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test;
  end
  // main sequence
  initial
  begin
    logic [31:0] q;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0000);
    rc(sirq_pkg::ADDR_IRQ_SELECT, 32'h0000_0000);
    rc(8'h1c, 32'h0000_0000);
    frame(16'h0000);
    $display("reset test done");
    wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_004e);
    rc(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_004e);
    frame(16'h0241);
    wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0040);
    wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_004e);
    rc(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0040);
    rd(sirq_pkg::ADDR_ENABLE_CTRL, q);
    wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0042);
    wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0040);
    wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0042);
    rc(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0040);
    $display("direct test done");
    for (int i = 0; i < 3; i++)
    begin
      rd(sirq_pkg::ADDR_ENABLE_CTRL, q);
      wr(sirq_pkg::ADDR_ENABLE_CTRL, {24'h00_0000, EN[i]});
      frame(16'h0000);
      pulse(0, 1);
      frame(EXP[i]);
      pulse(1, 1);
      rc(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_0000);
    end
    $display("flag test done");
    rc(sirq_pkg::ADDR_EVT_STATUS, 32'h0000_0007);
    wr(sirq_pkg::ADDR_EVT_ENABLE, 32'h0000_0004);
    ci(1'b1);
    wr(sirq_pkg::ADDR_EVT_ENABLE, 32'h0000_0000);
    ci(1'b0);
    wr(sirq_pkg::ADDR_EVT_CLEAR, 32'h0000_0007);
    rc(sirq_pkg::ADDR_EVT_STATUS, 32'h0000_0000);
    wr(sirq_pkg::ADDR_EVT_ENABLE, 32'h0000_0001);
    pulse(0, 1);
    ci(1'b1);
    wr(sirq_pkg::ADDR_EVT_CLEAR, 32'h0000_0001);
    ci(1'b0);
    rc(sirq_pkg::ADDR_LINK_STATUS, 32'h0000_0001);
    $display("interrupt test done");
    for (int b = 2; b < 4; b++)
    begin
      rd(sirq_pkg::ADDR_ENABLE_CTRL, q);
      wr(sirq_pkg::ADDR_ENABLE_CTRL, 32'h0000_004e);
      pulse(b, 3);
      rd(sirq_pkg::ADDR_ENABLE_CTRL, q);
      chk(q & 32'h0000_000e, 32'h0000_0000);
    end
    $display("lpc reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(sirq_pkg::ADDR_IRQ_SELECT, 32'h0000_0001 << i);
      rc(sirq_pkg::ADDR_IRQ_SELECT, 32'h0000_0001 << i);
      frame(16'h0001 << SEL_IRQ[i]);
    end
    $display("select test done");
    end_of_test;
  end
endmodule // serirq_host_irq_ch4_select_bench
`default_nettype wire
